// >>> shared/upees_pkg.sv
// Purpose: constants and carriers for the line event enable/status block
// Assumes: 8-bit register data, 6-bit register address, 25 MHz clock
// Notes: indicator bit layout is shared by enables, status and latch
package upees_pkg;

  localparam int REG_AW = 6;
  localparam int REG_DW = 8;
  localparam int IND_W = 5;

  // register offsets
  localparam logic [5:0] OFS_RISE = 6'h0d;
  localparam logic [5:0] OFS_RISE_SET = 6'h0e;
  localparam logic [5:0] OFS_RISE_CLR = 6'h0f;
  localparam logic [5:0] OFS_FALL = 6'h10;
  localparam logic [5:0] OFS_FALL_SET = 6'h11;
  localparam logic [5:0] OFS_FALL_CLR = 6'h12;
  localparam logic [5:0] OFS_STATUS = 6'h13;
  localparam logic [5:0] OFS_LATCH = 6'h14;

  // field positions inside every register of the block
  localparam int BIT_ID = 4;
  localparam int BIT_SESS_END = 3;
  localparam int BIT_SESS_OK = 2;
  localparam int BIT_SUPPLY = 1;
  localparam int BIT_HOST = 0;

  // reset values
  localparam logic [4:0] RISE_EN_RST = 5'h1f;
  localparam logic [4:0] FALL_EN_RST = 5'h1f;
  localparam logic [4:0] LATCH_RST = 5'h00;
  localparam logic [4:0] STATUS_RST = 5'h00;
  localparam logic [2:0] RSVD_BITS = 3'h0;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // id sampling settle time
  localparam int ID_MASK_MS = 50;
  localparam int CLK_HZ = 25_000_000;
  localparam int ID_MASK_CYCLES = ID_MASK_MS * (CLK_HZ / 1000);

  // live indicators, bit order matches the register layout
  typedef struct packed {
    logic idGrounded;
    logic sessionEnd;
    logic sessionOk;
    logic supplyOk;
    logic hostDetached;
  } upees_ind_s;

  // one register access from the link side
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } upees_req_s;

  // pull resistor control bits
  typedef struct packed {
    logic idPullUpEnable;
    logic plusLinePulldownEnable;
    logic minusLinePulldownEnable;
  } upees_pull_s;

  // operating modes that clear the latch on entry
  typedef struct packed {
    logic lowPower;
    logic serial;
    logic carkit;
  } upees_mode_s;

endpackage

// >>> rtl/upees_event_regs.sv
// Purpose: edge enables, live status and event latch for five line indicators
// Assumes: indicator, pull and mode inputs are synchronous to clk
// Notes: aliases share one storage; reads answer one cycle after the request
`timescale 1ns/1ps

module upees_event_regs
  import upees_pkg::*;
#(
  parameter int ID_MASK_CYC = ID_MASK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register access from the link side
  input wire upees_req_s req,
  output logic [7:0] rdDataReg,
  output logic rdValidReg,
  // analog indicators and control bits
  input wire upees_ind_s ind,
  input wire upees_pull_s pull,
  input wire upees_mode_s mode,
  // event notification toward the receive command path
  output logic [4:0] eventReg,
  output logic [4:0] latchReg
);

  localparam int CNT_W = $clog2(ID_MASK_CYC + 1);
  localparam logic [CNT_W-1:0] ID_CNT_LOAD = CNT_W'(ID_MASK_CYC);

  //////////////////////////////////////////////////////////////////////////
  // helpers

  // set or clear style write into a five-bit enable
  function automatic logic [4:0] apply_alias(input logic [4:0] cur,
                                             input logic [7:0] data,
                                             input logic isSet,
                                             input logic isClr);
    logic [4:0] res;
    res = cur;
    if (isSet) begin
      res = cur | data[4:0];
    end else if (isClr) begin
      res = cur & ~data[4:0];
    end else begin
      res = data[4:0];
    end
    return res;
  endfunction

  // one five-bit field widened to a register byte
  function automatic logic [7:0] as_byte(input logic [4:0] v);
    return {RSVD_BITS, v};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // state

  logic [4:0] riseEnReg, riseEnNext;
  logic [4:0] fallEnReg, fallEnNext;
  logic [4:0] statusReg, statusNext;
  logic [4:0] latchNext;
  logic [4:0] eventNext;
  logic [2:0] modeReg;
  logic [CNT_W-1:0] idCntReg, idCntNext;
  logic [7:0] rdDataNext;
  logic rdValidNext;
  logic idMasked;
  logic hostMode;
  logic latchClr;
  logic [4:0] indBits;
  logic [4:0] riseEdge, fallEdge;

  //////////////////////////////////////////////////////////////////////////
  // next-state logic

  // session_ok arrives already equal to the a-device session valid
  assign indBits = ind;

  // mask held from pull-up off until the settle count expires
  assign idMasked = !pull.idPullUpEnable || (idCntReg != '0);
  assign hostMode = pull.plusLinePulldownEnable &&
                    pull.minusLinePulldownEnable;

  always_comb begin
    // settle counter reloads whenever sampling is off
    idCntNext = idCntReg;
    if (!pull.idPullUpEnable) begin
      idCntNext = ID_CNT_LOAD;
    end else if (idCntReg != '0) begin
      idCntNext = idCntReg - 1'b1;
    end

    // live status, id frozen while masked, host forced low in low power
    statusNext = indBits;
    if (idMasked) begin
      statusNext[BIT_ID] = statusReg[BIT_ID];
    end
    if (mode.lowPower) begin
      statusNext[BIT_HOST] = 1'b0;
    end

    // edges against the previous cycle's value
    riseEdge = statusNext & ~statusReg & riseEnReg;
    fallEdge = ~statusNext & statusReg & fallEnReg;
    eventNext = riseEdge | fallEdge;
    if (idMasked) begin
      eventNext[BIT_ID] = 1'b0;
    end
    if (!hostMode) begin
      eventNext[BIT_HOST] = 1'b0;
    end
    // forced-low host status in low power is not a line change
    if (mode.lowPower) begin
      eventNext[BIT_HOST] = 1'b0;
    end

    // enable storage, aliases land in the same write cycle
    riseEnNext = riseEnReg;
    fallEnNext = fallEnReg;
    if (req.wr) begin
      unique case (req.addr)
        OFS_RISE: riseEnNext = apply_alias(riseEnReg, req.wdata,
                                           1'b0, 1'b0);
        OFS_RISE_SET: riseEnNext = apply_alias(riseEnReg, req.wdata,
                                               1'b1, 1'b0);
        OFS_RISE_CLR: riseEnNext = apply_alias(riseEnReg, req.wdata,
                                               1'b0, 1'b1);
        OFS_FALL: fallEnNext = apply_alias(fallEnReg, req.wdata,
                                           1'b0, 1'b0);
        OFS_FALL_SET: fallEnNext = apply_alias(fallEnReg, req.wdata,
                                               1'b1, 1'b0);
        OFS_FALL_CLR: fallEnNext = apply_alias(fallEnReg, req.wdata,
                                               1'b0, 1'b1);
        default: ;
      endcase
    end

    // latch clears on read or mode entry; a new event wins over the clear
    latchClr = (req.rd && req.addr == OFS_LATCH) ||
               (|(mode & ~modeReg));
    latchNext = (latchClr ? LATCH_RST : latchReg) | eventNext;

    // read data shows the value before any same-cycle write
    rdValidNext = req.rd;
    rdDataNext = UNMAPPED_DATA;
    if (req.rd) begin
      unique case (req.addr)
        OFS_RISE, OFS_RISE_SET, OFS_RISE_CLR:
          rdDataNext = as_byte(riseEnReg);
        OFS_FALL, OFS_FALL_SET, OFS_FALL_CLR:
          rdDataNext = as_byte(fallEnReg);
        OFS_STATUS: rdDataNext = as_byte(statusReg);
        OFS_LATCH: rdDataNext = as_byte(latchReg);
        default: rdDataNext = UNMAPPED_DATA;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registers

  // host bit is loaded from the line so it reflects attach state
  always_ff @(posedge clk) begin
    if (srst) begin
      riseEnReg <= RISE_EN_RST;
      fallEnReg <= FALL_EN_RST;
      statusReg <= STATUS_RST | {4'h0, ind.hostDetached};
      latchReg <= LATCH_RST;
      eventReg <= '0;
      modeReg <= '0;
      idCntReg <= ID_CNT_LOAD;
      rdDataReg <= UNMAPPED_DATA;
      rdValidReg <= 1'b0;
    end else begin
      riseEnReg <= riseEnNext;
      fallEnReg <= fallEnNext;
      statusReg <= statusNext;
      latchReg <= latchNext;
      eventReg <= eventNext;
      modeReg <= mode;
      idCntReg <= idCntNext;
      rdDataReg <= rdDataNext;
      rdValidReg <= rdValidNext;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_rise_set;
    req.wr && req.addr == OFS_RISE_SET |=>
      riseEnReg == ($past(riseEnReg) | $past(req.wdata[4:0]));
  endproperty
  a_rise_set: assert property (p_rise_set)
    else $error("rising set alias wrong");

  property p_rise_clr;
    req.wr && req.addr == OFS_RISE_CLR |=>
      riseEnReg == ($past(riseEnReg) & ~$past(req.wdata[4:0]));
  endproperty
  a_rise_clr: assert property (p_rise_clr)
    else $error("rising clear alias wrong");

  property p_fall_set;
    req.wr && req.addr == OFS_FALL_SET |=>
      fallEnReg == ($past(fallEnReg) | $past(req.wdata[4:0]));
  endproperty
  a_fall_set: assert property (p_fall_set)
    else $error("falling set alias wrong");

  property p_fall_clr;
    req.wr && req.addr == OFS_FALL_CLR |=>
      fallEnReg == ($past(fallEnReg) & ~$past(req.wdata[4:0]));
  endproperty
  a_fall_clr: assert property (p_fall_clr)
    else $error("falling clear alias wrong");

  property p_fall_reset;
    disable iff (1'b0) srst |=> fallEnReg == 5'h1f && riseEnReg == 5'h1f;
  endproperty
  a_fall_reset: assert property (p_fall_reset)
    else $error("enables not all ones after reset");

  property p_id_hold;
    !pull.idPullUpEnable ##1 pull.idPullUpEnable |->
      $stable(statusReg[BIT_ID]) [*8] and !eventReg[BIT_ID] [*8];
  endproperty
  a_id_hold: assert property (p_id_hold)
    else $error("id bit moved during settle time");

  property p_host_mode;
    !hostMode |=> !eventReg[BIT_HOST];
  endproperty
  a_host_mode: assert property (p_host_mode)
    else $error("host event outside host mode");

  property p_low_power;
    mode.lowPower |=> !statusReg[BIT_HOST];
  endproperty
  a_low_power: assert property (p_low_power)
    else $error("low power did not clear host status");

  // only the entry clears; events while held in low power still latch
  property p_low_power_clr;
    $rose(mode.lowPower) |=> latchReg == $past(eventNext);
  endproperty
  a_low_power_clr: assert property (p_low_power_clr)
    else $error("latch not cleared on low power entry");

  property p_status_read;
    req.rd && req.addr == OFS_STATUS |=>
      rdValidReg && rdDataReg == {3'h0, $past(statusReg)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read data wrong");

  property p_latch_read;
    req.rd && req.addr == OFS_LATCH && eventNext == '0 |=> latchReg == '0;
  endproperty
  a_latch_read: assert property (p_latch_read)
    else $error("latch not cleared by read");

  property p_mode_entry;
    $rose(mode.serial) || $rose(mode.carkit) |=>
      latchReg == $past(eventNext);
  endproperty
  a_mode_entry: assert property (p_mode_entry)
    else $error("latch not cleared on mode entry");

  property p_rise_write;
    req.wr && req.addr == OFS_RISE |=>
      riseEnReg == $past(req.wdata[4:0]);
  endproperty
  a_rise_write: assert property (p_rise_write)
    else $error("rising base register write wrong");

  // reserved bits never leak onto the read bus
  property p_rsvd_zero;
    rdDataReg[7:5] == RSVD_BITS;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved read bits not zero");

  c_id_event: cover property (eventReg[BIT_ID]);
  c_host_fall: cover property (hostMode && $fell(statusReg[BIT_HOST]));
  c_latch_read: cover property (req.rd && req.addr == OFS_LATCH &&
                                latchReg != '0);
  c_alias_write: cover property (req.wr && req.addr == OFS_FALL_CLR);

endmodule

// >>> dv/upees_link_model.sv
// Purpose: link-side model that issues register reads and writes
// Assumes: one strobe per access, answer one cycle after the read edge
// Notes: address and data go to junk between accesses so stale use shows
`timescale 1ns/1ps
module upees_link_model
  import upees_pkg::*;
(
  // clock
  input wire logic clk,
  // request toward the registers
  output upees_req_s req,
  // read answer
  input wire logic [7:0] rdDataReg,
  input wire logic rdValidReg
);
  // idle cycles after each access, raise to act as a slow link
  int gap = 0;

  // nothing requested at time zero
  initial req = '{wr: 1'b0, rd: 1'b0, addr: 6'h3f, wdata: 8'ha5};

  //////////////////////////////////////////////////////////////////////////
  // one access; the answer is taken once the answering edge has landed
  task automatic access(input logic w, input logic [5:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    #1;
    q = rdDataReg;
    if (!w && rdValidReg !== 1'b1) begin
      q = 8'hxx; // missing answer must not pass for data
    end
    repeat (gap) @(posedge clk);
  endtask
endmodule

// >>> dv/usb_phy_event_enable_status_tb.sv
// Purpose: self-checking bench for the line event enable/status block
// Assumes: id settle window shortened to 20 cycles
// Notes: events are collected over a short window, not a fixed cycle
`timescale 1ns/1ps
module usb_phy_event_enable_status_tb
  import upees_pkg::*;
();
  localparam int MASK = 20;
  logic clk = 1'b0;
  logic srst = 1'b1;
  upees_req_s req;
  upees_ind_s ind = 5'h01;
  upees_pull_s pull = 3'h7;
  upees_mode_s mode = 3'h0;
  logic [7:0] rdDataReg;
  logic rdValidReg;
  logic [4:0] eventReg;
  logic [4:0] latchReg;
  logic [4:0] evSeen;
  int bad_count = 0;
  int num_checks = 0;

  // 25 MHz clock
  always #20 clk = ~clk;

  upees_event_regs #(.ID_MASK_CYC(MASK)) i_dut (.clk(clk), .srst(srst),
    .req(req), .rdDataReg(rdDataReg), .rdValidReg(rdValidReg), .ind(ind),
    .pull(pull), .mode(mode), .eventReg(eventReg), .latchReg(latchReg));

  upees_link_model i_link (.clk(clk), .req(req), .rdDataReg(rdDataReg),
    .rdValidReg(rdValidReg));

  //////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] q;
    i_link.access(1'b0, a, 8'h00, q);
    check(q, exp);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_link.access(1'b1, a, d, q);
  endtask

  // change the indicators, then gather event pulses for three cycles
  task automatic drive(input logic [4:0] v);
    @(posedge clk);
    ind <= upees_ind_s'(v);
    evSeen = 5'h00;
    repeat (3) begin
      @(posedge clk);
      #1;
      evSeen = evSeen | eventReg;
    end
  endtask

  // enter a mode and wait two cycles so the caller can look at the latch
  task automatic enter(input logic [2:0] m);
    @(posedge clk);
    mode <= upees_mode_s'(m);
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rd(OFS_RISE, 8'h1f);
    rd(OFS_FALL, 8'h1f);
    rd(OFS_STATUS, 8'h01);
    $display("test reset done");
  endtask

  task automatic t_alias();
    wr(OFS_RISE_CLR, 8'he5);
    rd(OFS_RISE_SET, 8'h1a);
    wr(OFS_RISE_SET, 8'h21);
    rd(OFS_RISE_CLR, 8'h1b);
    wr(OFS_FALL_CLR, 8'h0a);
    rd(OFS_FALL_SET, 8'h15);
    wr(OFS_FALL_SET, 8'h08);
    rd(OFS_FALL_CLR, 8'h1d);
    wr(OFS_FALL, 8'hff);
    rd(OFS_FALL, 8'h1f);
    wr(OFS_STATUS, 8'h1e);
    rd(OFS_STATUS, 8'h01);
    rd(6'h20, UNMAPPED_DATA);
    wr(OFS_RISE, 8'hea);
    rd(OFS_RISE, 8'h0a);
    wr(OFS_RISE_SET, 8'h1f);
    $display("test alias done");
  endtask

  // session-end, session-ok and supply bits, both directions
  task automatic t_events();
    logic [4:0] b;
    for (int i = 1; i < 4; i++) begin
      b = 5'h01 << i;
      drive(ind ^ b);
      check({3'h0, evSeen}, {3'h0, b});
      drive(ind ^ b);
      check({3'h0, evSeen}, {3'h0, b});
    end
    check({3'h0, latchReg}, 8'h0e);
    rd(OFS_LATCH, 8'h0e);
    check({3'h0, latchReg}, 8'h00);
    wr(OFS_FALL_CLR, 8'h02);
    drive(5'h03);
    check({3'h0, evSeen}, 8'h02);
    drive(5'h01);
    check({3'h0, evSeen}, 8'h00);
    wr(OFS_FALL_SET, 8'h02);
    $display("test events done");
  endtask

  task automatic t_host();
    @(posedge clk);
    pull <= 3'h4; // pulldowns off, not host mode
    drive(5'h00);
    check({3'h0, evSeen}, 8'h00);
    @(posedge clk);
    pull <= 3'h7;
    drive(5'h01);
    check({3'h0, evSeen}, 8'h01);
    enter(3'h2);
    check({3'h0, latchReg}, 8'h00);
    enter(3'h0);
    drive(5'h00);
    enter(3'h1);
    check({3'h0, latchReg}, 8'h00);
    enter(3'h0);
    drive(5'h01);
    enter(3'h4);
    check({3'h0, latchReg}, 8'h00);
    rd(OFS_STATUS, 8'h00);
    enter(3'h0);
    $display("test host done");
  endtask

  task automatic t_id();
    rd(OFS_LATCH, 8'h01);
    @(posedge clk);
    pull <= 3'h3; // id sampling off
    drive(5'h11);
    check({3'h0, evSeen}, 8'h00);
    rd(OFS_STATUS, 8'h01);
    @(posedge clk);
    pull <= 3'h7;
    repeat (5) @(posedge clk);
    rd(OFS_STATUS, 8'h01);
    repeat (MASK + 5) @(posedge clk);
    rd(OFS_STATUS, 8'h11);
    check({3'h0, latchReg}, 8'h10);
    $display("test id done");
  endtask

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_alias();
    t_events();
    t_host();
    t_id();
    results();
  end

  // watchdog, far beyond the fewer than two hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    results();
  end
endmodule
